/* dtc_top.sv */
// dual timer/counter unit with external interrupt edge flags
//
// Local design decisions: the strobed register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "dtc_consts.svh"

module dtc_top (
    // clock and reset
    input  wire logic                   clk_sys_in,
    input  wire logic                   nrst_in,
    // register port
    input  wire logic [`DTC_ADDR_W-1:0] addr_in,
    input  wire logic [7:0]             wr_data_in,
    input  wire logic                   wr_en_in,
    input  wire logic                   rd_en_in,
    output logic      [7:0]             rd_data_out,
    // pins: external interrupts double as gate inputs
    input  wire logic                   int0_pin_in,
    input  wire logic                   int1_pin_in,
    input  wire logic                   t0_pin_in,
    input  wire logic                   t1_pin_in,
    // vectoring handshake with the core
    input  wire logic [1:0]             ack_tf_in,
    input  wire logic [1:0]             ack_ie_in,
    output logic      [1:0]             tf_req_out,
    output logic      [1:0]             ie_req_out,
    // interrupt
    output logic                        irq_out
);

    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!nrst_in);

    ////////////////////////////////////////////////////////////////////
    // state
    logic [1:0]            tf_r, tr_r, ie_r, it_r;
    logic [1:0]            tf_nxt, ie_nxt;
    logic [7:0]            timer_mode_r;
    logic [7:0]            tl_r [2];
    logic [7:0]            th_r [2];
    logic [7:0]            tl_nxt [2];
    logic [7:0]            th_nxt [2];
    logic [`DTC_NSTAT-1:0] stat_r, mask_r, stat_nxt, mask_nxt, evt;
    logic [1:0]            int_prev_r;
    logic [7:0]            rd_data_r;
    logic                  irq_r;

    ////////////////////////////////////////////////////////////////////
    // functions
    function automatic logic hit(input logic [`DTC_ADDR_W-1:0] a,
                                 input logic [`DTC_ADDR_W-1:0] idx);
        hit = (a == idx);
    endfunction : hit

    // one count step: {overflow, high, low}
    function automatic logic [16:0] cnt_step(input dtc_pkg::dtc_mode_type m,
                                             input logic [7:0] lo,
                                             input logic [7:0] hi);
        logic [13:0] v13;
        logic [16:0] v17;
        logic [8:0]  v9;
        v13 = {1'b0, hi, lo[`DTC_PRE_W-1:0]} + 14'h0001;
        v17 = {1'b0, hi, lo} + 17'h00001;
        v9  = {1'b0, lo} + 9'h001;
        case (m)
            dtc_pkg::dtc_m13: begin
                cnt_step = {v13[13], v13[12:`DTC_PRE_W], lo[7:`DTC_PRE_W],
                            v13[`DTC_PRE_W-1:0]};
            end
            dtc_pkg::dtc_m16: begin
                cnt_step = v17;
            end
            dtc_pkg::dtc_m8_reload: begin
                cnt_step = {v9[8], hi, v9[8] ? hi : v9[7:0]};
            end
            default: begin
                cnt_step = {1'b0, hi, lo};
            end
        endcase
    endfunction : cnt_step

    ////////////////////////////////////////////////////////////////////
    // decode
    wire rd_stat = rd_en_in & hit(addr_in, `DTC_IDX_STAT);
    wire wr_ctrl = wr_en_in & hit(addr_in, `DTC_IDX_CTRL);
    wire wr_mode = wr_en_in & hit(addr_in, `DTC_IDX_MODE);
    wire wr_mask = wr_en_in & hit(addr_in, `DTC_IDX_MASK);
    wire [1:0] wr_lo = {wr_en_in & hit(addr_in, `DTC_IDX_T1LO),
                        wr_en_in & hit(addr_in, `DTC_IDX_T0LO)};
    wire [1:0] wr_hi = {wr_en_in & hit(addr_in, `DTC_IDX_T1HI),
                        wr_en_in & hit(addr_in, `DTC_IDX_T0HI)};

    wire dtc_pkg::dtc_mode_type m0 =
        dtc_pkg::dtc_mode_type'(timer_mode_r[`DTC_M_T0_LSB +: 2]);
    wire dtc_pkg::dtc_mode_type m1 =
        dtc_pkg::dtc_mode_type'(timer_mode_r[`DTC_M_T1_LSB +: 2]);

    wire [7:0] ctrl_rd = {tf_r[1], tr_r[1], tf_r[0], tr_r[0],
                          ie_r[1], it_r[1], ie_r[0], it_r[0]};

    wire [7:0] rd_mux =
        hit(addr_in, `DTC_IDX_CTRL) ? ctrl_rd :
        hit(addr_in, `DTC_IDX_MODE) ? timer_mode_r :
        hit(addr_in, `DTC_IDX_T0LO) ? tl_r[0] :
        hit(addr_in, `DTC_IDX_T0HI) ? th_r[0] :
        hit(addr_in, `DTC_IDX_T1LO) ? tl_r[1] :
        hit(addr_in, `DTC_IDX_T1HI) ? th_r[1] :
        hit(addr_in, `DTC_IDX_STAT) ? {4'h0, stat_r} :
        hit(addr_in, `DTC_IDX_MASK) ? {4'h0, mask_r} : 8'h00;

    ////////////////////////////////////////////////////////////////////
    // count enables, one unit per timer
    wire [1:0] tick;
    wire [1:0] cnt_pin  = {t1_pin_in, t0_pin_in};
    wire [1:0] gate_pin = {int1_pin_in, int0_pin_in};

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_tick
            dtc_tick u_tick (
                .clk_sys_in  (clk_sys_in),
                .nrst_in     (nrst_in),
                .run_in      (tr_r[g]),
                .gate_en_in  (timer_mode_r[`DTC_M_GATE + 4 * g]),
                .cnt_sel_in  (timer_mode_r[`DTC_M_CT + 4 * g]),
                .gate_pin_in (gate_pin[g]),
                .cnt_pin_in  (cnt_pin[g]),
                .tick_out    (tick[g])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // counters
    wire [16:0] st0 = cnt_step(m0, tl_r[0], th_r[0]);
    wire [16:0] st1 = cnt_step(m1, tl_r[1], th_r[1]);
    wire [8:0]  sp_lo = {1'b0, tl_r[0]} + 9'h001;
    wire [8:0]  sp_hi = {1'b0, th_r[0]} + 9'h001;
    // split mode: high byte of timer0 is a plain timer run by timer1's run bit
    wire        split  = (m0 == dtc_pkg::dtc_m_split);
    wire        hi_tick = split & tr_r[1];

    // software write wins over a count in the same cycle
    assign tl_nxt[0] = wr_lo[0] ? wr_data_in :
                       tick[0] ? (split ? sp_lo[7:0] : st0[7:0]) :
                       tl_r[0];
    assign th_nxt[0] = wr_hi[0] ? wr_data_in :
                       split ? (hi_tick ? sp_hi[7:0] : th_r[0]) :
                       tick[0] ? st0[15:8] : th_r[0];
    assign tl_nxt[1] = wr_lo[1] ? wr_data_in : tick[1] ? st1[7:0] : tl_r[1];
    assign th_nxt[1] = wr_hi[1] ? wr_data_in : tick[1] ? st1[15:8] : th_r[1];

    // timer1 gives up its flag to timer0's high byte in split mode
    wire [1:0] tf_set = {(hi_tick & sp_hi[8]) | (tick[1] & st1[16] & ~split),
                         tick[0] & (split ? sp_lo[8] : st0[16])};

    ////////////////////////////////////////////////////////////////////
    // flags: hardware set beats software write and acknowledge
    wire [1:0] tf_wr = {wr_data_in[`DTC_C_TF1], wr_data_in[`DTC_C_TF0]};
    wire [1:0] ie_wr = {wr_data_in[`DTC_C_IE1], wr_data_in[`DTC_C_IE0]};
    wire [1:0] ie_edge = {int_prev_r[1] ^ int1_pin_in,
                          int_prev_r[0] & ~int0_pin_in};
    wire [1:0] pin_low = {~int1_pin_in, ~int0_pin_in};

    generate
        for (g = 0; g < 2; g++) begin : g_flag
            assign tf_nxt[g] = tf_set[g] ? 1'b1 : wr_ctrl ? tf_wr[g] :
                               ack_tf_in[g] ? 1'b0 : tf_r[g];
            // level mode: flag tracks the pin, so no acknowledge is needed
            assign ie_nxt[g] = ~it_r[g] ? pin_low[g] :
                               ie_edge[g] ? 1'b1 : wr_ctrl ? ie_wr[g] :
                               ack_ie_in[g] ? 1'b0 : ie_r[g];
        end
    endgenerate

    assign evt[`DTC_S_TF0] = tf_set[0];
    assign evt[`DTC_S_TF1] = tf_set[1];
    assign evt[`DTC_S_IE0] = ie_nxt[0] & ~ie_r[0];
    assign evt[`DTC_S_IE1] = ie_nxt[1] & ~ie_r[1];
    assign stat_nxt = (rd_stat ? `DTC_RST_STAT : stat_r) | evt;
    assign mask_nxt = wr_mask ? wr_data_in[`DTC_NSTAT-1:0] : mask_r;

    ////////////////////////////////////////////////////////////////////
    // registers
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            tf_r       <= 2'h0;
            tr_r       <= 2'h0;
            ie_r       <= 2'h0;
            it_r       <= 2'h0;
            int_prev_r <= 2'h3;
            timer_mode_r     <= `DTC_RST_BYTE;
            stat_r     <= `DTC_RST_STAT;
            mask_r     <= `DTC_RST_STAT;
            rd_data_r  <= `DTC_RST_BYTE;
            irq_r      <= 1'b0;
        end else begin
            tf_r       <= tf_nxt;
            ie_r       <= ie_nxt;
            int_prev_r <= {int1_pin_in, int0_pin_in};
            if (wr_ctrl) begin
                tr_r <= {wr_data_in[`DTC_C_TR1], wr_data_in[`DTC_C_TR0]};
                it_r <= {wr_data_in[`DTC_C_IT1], wr_data_in[`DTC_C_IT0]};
            end
            if (wr_mode) begin
                timer_mode_r <= wr_data_in;
            end
            stat_r     <= stat_nxt;
            mask_r     <= mask_nxt;
            rd_data_r  <= rd_en_in ? rd_mux : `DTC_RST_BYTE;
            irq_r      <= |(stat_nxt & mask_nxt);
        end
    end

    generate
        for (g = 0; g < 2; g++) begin : g_cnt
            always_ff @(posedge clk_sys_in or negedge nrst_in) begin
                if (!nrst_in) begin
                    tl_r[g] <= `DTC_RST_BYTE;
                    th_r[g] <= `DTC_RST_BYTE;
                end else begin
                    tl_r[g] <= tl_nxt[g];
                    th_r[g] <= th_nxt[g];
                end
            end
        end
    endgenerate

    assign rd_data_out = rd_data_r;
    assign irq_out     = irq_r;
    assign tf_req_out  = tf_r;
    assign ie_req_out  = ie_r;

    ////////////////////////////////////////////////////////////////////
    // checks
    wire no_wr = ~wr_en_in;

    sequence s_t0_wrap;
        tick[0] && m0 == dtc_pkg::dtc_m16 && tl_r[0] == `DTC_BYTE_MAX
            && th_r[0] == `DTC_BYTE_MAX && no_wr;
    endsequence
    property p_tf0_set;
        s_t0_wrap |=> tf_r[0] && tl_r[0] == 8'h00 && th_r[0] == 8'h00;
    endproperty
    a_tf0_set: assert property (p_tf0_set) else $error("t0 wrap lost flag");

    property p_tf_ack;
        ack_tf_in[0] && !tf_set[0] && no_wr |=> !tf_r[0];
    endproperty
    a_tf_ack: assert property (p_tf_ack) else $error("ack left flag set");

    property p_stop;
        !tr_r[1] && no_wr |=> $stable(tl_r[1]) && $stable(th_r[1]);
    endproperty
    a_stop: assert property (p_stop) else $error("timer1 moved while off");

    property p_ie1_edge;
        it_r[1] && (int_prev_r[1] != int1_pin_in) |=> ie_r[1];
    endproperty
    a_ie1_edge: assert property (p_ie1_edge) else $error("int1 edge missed");

    property p_ie1_level;
        !it_r[1] |=> ie_r[1] == !$past(int1_pin_in);
    endproperty
    a_ie1_level: assert property (p_ie1_level) else $error("int1 level");

    property p_ie0_fall;
        it_r[0] && int_prev_r[0] && !int0_pin_in |=> ie_r[0];
    endproperty
    a_ie0_fall: assert property (p_ie0_fall) else $error("int0 fall missed");

    property p_ie0_rise;
        it_r[0] && !ie_r[0] && !int_prev_r[0] && no_wr |=> !ie_r[0];
    endproperty
    a_ie0_rise: assert property (p_ie0_rise) else $error("int0 set on rise");

    property p_hi_write;
        wr_en_in && hit(addr_in, `DTC_IDX_T0HI) |=> th_r[0] == $past(wr_data_in);
    endproperty
    a_hi_write: assert property (p_hi_write) else $error("high byte write");

    property p_pre32;
        tick[1] && m1 == dtc_pkg::dtc_m13 && tl_r[1][4:0] == 5'h1F && no_wr
            |=> th_r[1] == $past(th_r[1]) + 8'h01 && tl_r[1][4:0] == 5'h00;
    endproperty
    a_pre32: assert property (p_pre32) else $error("prescaler carry");

    property p_m16;
        tick[1] && m1 == dtc_pkg::dtc_m16 && tl_r[1] != `DTC_BYTE_MAX && no_wr
            |=> $stable(th_r[1]) && tl_r[1] == $past(tl_r[1]) + 8'h01;
    endproperty
    a_m16: assert property (p_m16) else $error("16-bit step");

    property p_reload;
        tick[1] && m1 == dtc_pkg::dtc_m8_reload && tl_r[1] == `DTC_BYTE_MAX
            && no_wr |=> tl_r[1] == th_r[1] && $stable(th_r[1]);
    endproperty
    a_reload: assert property (p_reload) else $error("reload failed");

    property p_m3_stop;
        m1 == dtc_pkg::dtc_m_split && no_wr |=> $stable(tl_r[1]);
    endproperty
    a_m3_stop: assert property (p_m3_stop) else $error("timer1 not stopped");

    property p_mode_wr;
        wr_mode |=> timer_mode_r == $past(wr_data_in);
    endproperty
    a_mode_wr: assert property (p_mode_wr) else $error("mode write");

    property p_split_hi;
        split && tr_r[1] && th_r[0] != `DTC_BYTE_MAX && no_wr
            |=> th_r[0] == $past(th_r[0]) + 8'h01;
    endproperty
    a_split_hi: assert property (p_split_hi) else $error("split high byte");

    property p_gate;
        timer_mode_r[`DTC_M_GATE] && !int0_pin_in && no_wr |=> $stable(tl_r[0]);
    endproperty
    a_gate: assert property (p_gate) else $error("gate ignored");

    property p_cnt_pin;
        timer_mode_r[`DTC_M_CT] && tr_r[0] && !timer_mode_r[`DTC_M_GATE] && no_wr
            && t0_pin_in ##1 (t0_pin_in && no_wr) |=> $stable(tl_r[0]);
    endproperty
    a_cnt_pin: assert property (p_cnt_pin) else $error("counted w/o edge");

    property p_flag_hold;
        tf_r[0] && !ack_tf_in[0] && no_wr |=> tf_r[0];
    endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("t0 flag dropped");

    property p_irq;
        ##1 irq_out == |(stat_r & mask_r);
    endproperty
    a_irq: assert property (p_irq) else $error("irq mismatch");

endmodule : dtc_top

`default_nettype wire

/* dtc_consts.svh */
// constants for the dual timer/counter unit
`ifndef DTC_CONSTS_SVH
`define DTC_CONSTS_SVH

// register indices on the register port
`define DTC_ADDR_W     4
`define DTC_IDX_CTRL   4'h0
`define DTC_IDX_MODE   4'h1
`define DTC_IDX_T0LO   4'h2
`define DTC_IDX_T0HI   4'h3
`define DTC_IDX_T1LO   4'h4
`define DTC_IDX_T1HI   4'h5
`define DTC_IDX_STAT   4'h6
`define DTC_IDX_MASK   4'h7

// timer_control bit positions
`define DTC_C_TF1      7
`define DTC_C_TR1      6
`define DTC_C_TF0      5
`define DTC_C_TR0      4
`define DTC_C_IE1      3
`define DTC_C_IT1      2
`define DTC_C_IE0      1
`define DTC_C_IT0      0

// timer_mode fields, per timer nibble
`define DTC_M_GATE     3
`define DTC_M_CT       2
`define DTC_M_T1_LSB   4
`define DTC_M_T0_LSB   0

// status and mask bit positions
`define DTC_S_TF0      0
`define DTC_S_TF1      1
`define DTC_S_IE0      2
`define DTC_S_IE1      3
`define DTC_NSTAT      4

// prescaler width in mode 00 (divide-by-32)
`define DTC_PRE_W      5

// reset values and the all-ones byte maximum
`define DTC_RST_BYTE   8'h00
`define DTC_RST_STAT   4'h0
`define DTC_BYTE_MAX   8'hFF

`endif

/* dtc_pkg.sv */
// types for the dual timer/counter unit
package dtc_pkg;

    // order matches the 2-bit timer_mode_field encoding
    typedef enum logic [1:0] {
        dtc_m13,
        dtc_m16,
        dtc_m8_reload,
        dtc_m_split
    } dtc_mode_type;

endpackage : dtc_pkg

/* dtc_tick.sv */
// count-enable unit for one timer: gating, source select, pin edge
`timescale 1ns/1ps
`default_nettype none

module dtc_tick (
    // clock and reset
    input  wire logic clk_sys_in,
    input  wire logic nrst_in,
    // control bits
    input  wire logic run_in,
    input  wire logic gate_en_in,
    input  wire logic cnt_sel_in,
    // pins
    input  wire logic gate_pin_in,
    input  wire logic cnt_pin_in,
    // count enable
    output logic      tick_out
);

    logic pin_prev_r;
    wire  run_ok;
    wire  pin_fall;

    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            pin_prev_r <= 1'b0;
        end else begin
            pin_prev_r <= cnt_pin_in;
        end
    end

    // external gate only matters when the gating bit is set
    assign run_ok   = run_in & (~gate_en_in | gate_pin_in);
    assign pin_fall = pin_prev_r & ~cnt_pin_in;
    // machine cycle equals one clock here
    assign tick_out = run_ok & (cnt_sel_in ? pin_fall : 1'b1);

endmodule : dtc_tick

`default_nettype wire

/* dtc_core_model.sv */
// behavioural core model answering timer and pin interrupt requests
`timescale 1ns/1ps
`default_nettype none

module dtc_core_model (
    // clock and reset
    input  wire logic       clk_sys_in,
    input  wire logic       nrst_in,
    // behaviour controls
    input  wire logic       ack_en_in,
    input  wire logic [3:0] ack_dly_in,
    // requests from the timer unit
    input  wire logic [1:0] tf_req_in,
    input  wire logic [1:0] ie_req_in,
    // vector acknowledges
    output logic      [1:0] ack_tf_out,
    output logic      [1:0] ack_ie_out
);
    ////////////////////////////////////////////////////////////////////////////////
    logic [3:0] req;
    logic [3:0] ack_r;
    logic [3:0] wait_r [4];

    assign req        = {ie_req_in, tf_req_in};
    assign ack_tf_out = ack_r[1:0];
    assign ack_ie_out = ack_r[3:2];

    ////////////////////////////////////////////////////////////////////////////////
    // one pulse per request; the guard stops a second pulse before the flag drops
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            ack_r <= 4'h0;
            for (int i = 0; i < 4; i++) begin
                wait_r[i] <= 4'h0;
            end
        end else begin
            for (int i = 0; i < 4; i++) begin
                ack_r[i] <= 1'b0;
                if (ack_en_in && req[i] && !ack_r[i]) begin
                    if (wait_r[i] >= ack_dly_in) begin
                        ack_r[i]  <= 1'b1;
                        wait_r[i] <= 4'h0;
                    end else begin
                        wait_r[i] <= wait_r[i] + 4'h1;
                    end
                end else begin
                    wait_r[i] <= 4'h0;
                end
            end
        end
    end
endmodule : dtc_core_model

`default_nettype wire

/* dtc_top_tb_top.sv */
// self-checking bench for the dual timer/counter unit
`timescale 1ns/1ps
`default_nettype none
`include "dtc_consts.svh"

module dtc_top_tb_top;
    logic       clk_sys_in  = 1'b0;
    logic       nrst_in     = 1'b0;
    logic [3:0] addr        = 4'h0;
    logic [7:0] wdata       = 8'h00;
    logic       wr_en       = 1'b0;
    logic       rd_en       = 1'b0;
    logic [7:0] rdata;
    logic       int0_pin    = 1'b1;
    logic       int1_pin    = 1'b1;
    logic       t0_pin      = 1'b1;
    logic       t1_pin      = 1'b1;
    logic [1:0] ack_tf;
    logic [1:0] ack_ie;
    logic [1:0] tf_req;
    logic [1:0] ie_req;
    logic       irq;
    logic       core_en     = 1'b0;
    logic [3:0] core_dly    = 4'h5;
    int         mismatches  = 0;
    int         comparisons = 0;
    int         cycles      = 0;
    logic [7:0] a;
    logic [7:0] b;

    always #12.5 clk_sys_in = ~clk_sys_in;

    dtc_top dut_u (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .addr_in(addr),
        .wr_data_in(wdata), .wr_en_in(wr_en), .rd_en_in(rd_en), .rd_data_out(rdata),
        .int0_pin_in(int0_pin), .int1_pin_in(int1_pin), .t0_pin_in(t0_pin),
        .t1_pin_in(t1_pin), .ack_tf_in(ack_tf), .ack_ie_in(ack_ie),
        .tf_req_out(tf_req), .ie_req_out(ie_req), .irq_out(irq));

    dtc_core_model core_u (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in),
        .ack_en_in(core_en), .ack_dly_in(core_dly), .tf_req_in(tf_req),
        .ie_req_in(ie_req), .ack_tf_out(ack_tf), .ack_ie_out(ack_ie));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [3:0] ad, input logic [7:0] d);
        @(posedge clk_sys_in);
        wr_en <= 1'b1;
        addr  <= ad;
        wdata <= d;
        @(posedge clk_sys_in);
        wr_en <= 1'b0;
    endtask : wr

    // data stands only in the cycle after the strobe
    task automatic rd(input logic [3:0] ad, output logic [7:0] d);
        @(posedge clk_sys_in);
        rd_en <= 1'b1;
        addr  <= ad;
        @(posedge clk_sys_in);
        rd_en <= 1'b0;
        #1 d = rdata;
    endtask : rd

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys_in);
        #1;
    endtask : cyc

    ////////////////////////////////////////////////////////////////////////////////
    task automatic sc_regs();
        for (int i = 0; i < 8; i++) begin
            rd(4'(i), a);
            chk("reset value", 8'h00, a);
        end
        rd(4'h9, a);
        chk("unmapped read", 8'h00, a);
        wr(`DTC_IDX_T0LO, 8'h5A);
        wr(`DTC_IDX_T0HI, 8'hA5);
        wr(`DTC_IDX_MODE, 8'hC3);
        rd(`DTC_IDX_T0LO, a);
        chk("timer0 low", 8'h5A, a);
        rd(`DTC_IDX_T0HI, a);
        chk("timer0 high", 8'hA5, a);
        rd(`DTC_IDX_MODE, a);
        chk("timer mode", 8'hC3, a);
        wr(`DTC_IDX_MODE, 8'h00);
    endtask : sc_regs

    task automatic sc_mode16();
        core_en <= 1'b0;
        rd(`DTC_IDX_STAT, a);
        wr(`DTC_IDX_T1LO, 8'hFE);
        wr(`DTC_IDX_T1HI, 8'hFF);
        wr(`DTC_IDX_T0LO, 8'hFE);
        wr(`DTC_IDX_T0HI, 8'hFF);
        wr(`DTC_IDX_MODE, 8'h11);
        wr(`DTC_IDX_CTRL, 8'h50);
        cyc(3);
        chk("overflow flags", 8'h03, {6'h0, tf_req});
        wr(`DTC_IDX_MASK, 8'h02);
        cyc(1);
        chk("irq masked in", 8'h01, {7'h0, irq});
        rd(`DTC_IDX_STAT, a);
        chk("status", 8'h03, a);
        chk("irq after status read", 8'h00, {7'h0, irq});
        rd(`DTC_IDX_T1HI, a);
        chk("timer1 high wrapped", 8'h00, a);
        core_en <= 1'b1;
        cyc(10);
        chk("flags after vector", 8'h00, {6'h0, tf_req});
        wr(`DTC_IDX_CTRL, 8'h00);
        wr(`DTC_IDX_MASK, 8'h00);
    endtask : sc_mode16

    task automatic sc_reload();
        core_en <= 1'b0;
        wr(`DTC_IDX_T1HI, 8'h80);
        wr(`DTC_IDX_T1LO, 8'hFE);
        wr(`DTC_IDX_MODE, 8'h20);
        wr(`DTC_IDX_CTRL, 8'h40);
        cyc(4);
        chk("t1 reload flag", 8'h01, {7'h0, tf_req[1]});
        rd(`DTC_IDX_T1LO, a);
        chk("reloaded low msb", 8'h01, {7'h0, a[7]});
        rd(`DTC_IDX_T1HI, b);
        chk("reload value kept", 8'h80, b);
        wr(`DTC_IDX_MODE, 8'h30);
        rd(`DTC_IDX_T1LO, a);
        cyc(3);
        rd(`DTC_IDX_T1LO, b);
        chk("timer1 stopped", a, b);
        wr(`DTC_IDX_CTRL, 8'h00);
    endtask : sc_reload

    task automatic sc_presc();
        wr(`DTC_IDX_T1LO, 8'hE0);
        wr(`DTC_IDX_T1HI, 8'h00);
        wr(`DTC_IDX_MODE, 8'h00);
        wr(`DTC_IDX_CTRL, 8'h40);
        cyc(40);
        wr(`DTC_IDX_CTRL, 8'h00);
        rd(`DTC_IDX_T1HI, a);
        chk("prescaled high", 8'h01, a);
        rd(`DTC_IDX_T1LO, b);
        chk("low top bits kept", 8'h07, {5'h0, b[7:5]});
    endtask : sc_presc

    task automatic sc_gate();
        wr(`DTC_IDX_T0LO, 8'h00);
        wr(`DTC_IDX_MODE, 8'h09);
        int0_pin <= 1'b0;
        wr(`DTC_IDX_CTRL, 8'h10);
        cyc(10);
        rd(`DTC_IDX_T0LO, a);
        chk("gate closed", 8'h00, a);
        int0_pin <= 1'b1;
        cyc(10);
        wr(`DTC_IDX_CTRL, 8'h00);
        rd(`DTC_IDX_T0LO, a);
        cyc(5);
        rd(`DTC_IDX_T0LO, b);
        chk("gate open", 8'h0C, a);
        chk("run bit off", a, b);
    endtask : sc_gate

    task automatic sc_pin();
        wr(`DTC_IDX_T0LO, 8'h00);
        wr(`DTC_IDX_MODE, 8'h05);
        wr(`DTC_IDX_CTRL, 8'h10);
        cyc(4);
        repeat (3) begin
            t0_pin <= 1'b0;
            cyc(2);
            t0_pin <= 1'b1;
            cyc(2);
        end
        wr(`DTC_IDX_CTRL, 8'h00);
        rd(`DTC_IDX_T0LO, a);
        chk("pin edges counted", 8'h03, a);
    endtask : sc_pin

    task automatic sc_split();
        wr(`DTC_IDX_T0LO, 8'h00);
        wr(`DTC_IDX_T0HI, 8'h00);
        wr(`DTC_IDX_MODE, 8'h03);
        wr(`DTC_IDX_CTRL, 8'h40);
        cyc(10);
        wr(`DTC_IDX_CTRL, 8'h00);
        rd(`DTC_IDX_T0LO, a);
        chk("split low idle", 8'h00, a);
        rd(`DTC_IDX_T0HI, b);
        chk("split high ran", 8'h0C, b);
        wr(`DTC_IDX_MODE, 8'h00);
    endtask : sc_split

    task automatic sc_ext();
        core_en  <= 1'b0;
        core_dly <= 4'h5;
        wr(`DTC_IDX_CTRL, 8'h05);
        int0_pin <= 1'b0;
        cyc(3);
        chk("int0 falling", 8'h01, {7'h0, ie_req[0]});
        core_en <= 1'b1;
        cyc(10);
        chk("int0 serviced", 8'h00, {7'h0, ie_req[0]});
        core_en  <= 1'b0;
        int0_pin <= 1'b1;
        cyc(3);
        chk("int0 rising", 8'h00, {7'h0, ie_req[0]});
        int1_pin <= 1'b0;
        cyc(3);
        chk("int1 falling", 8'h01, {7'h0, ie_req[1]});
        core_en <= 1'b1;
        cyc(10);
        chk("int1 serviced", 8'h00, {7'h0, ie_req[1]});
        core_en  <= 1'b0;
        int1_pin <= 1'b1;
        cyc(3);
        chk("int1 rising", 8'h01, {7'h0, ie_req[1]});
        core_en  <= 1'b1;
        core_dly <= 4'h0;
        cyc(4);
        wr(`DTC_IDX_CTRL, 8'h00);
        int0_pin <= 1'b0;
        int1_pin <= 1'b0;
        cyc(10);
        chk("low level held", 8'h03, {6'h0, ie_req});
        int0_pin <= 1'b1;
        int1_pin <= 1'b1;
        cyc(3);
        chk("level released", 8'h00, {6'h0, ie_req});
    endtask : sc_ext

    ////////////////////////////////////////////////////////////////////////////////
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : end_of_test

    // hang guard, well above the length of the sequence
    always @(posedge clk_sys_in) begin
        cycles <= cycles + 1;
        if (cycles == 8000) begin
            mismatches++;
            end_of_test();
        end
    end

    initial begin
        repeat (8) @(posedge clk_sys_in);
        nrst_in <= 1'b1;
        sc_regs();
        sc_mode16();
        sc_reload();
        sc_presc();
        sc_gate();
        sc_pin();
        sc_split();
        sc_ext();
        end_of_test();
    end
endmodule : dtc_top_tb_top

`default_nettype wire
